// ==== shared/bld_defines.svh ====
/*
 Register map, field positions, masks and reset values of the blit parameter registers.
 Assumes inclusion by bare name from the register block and the testbench.
*/
`ifndef BLD_DEFINES_SVH
`define BLD_DEFINES_SVH
`define BLD_AW          12
`define BLD_A_CMD       12'h200
`define BLD_A_SO        12'h20c
`define BLD_A_CC        12'h210
`define BLD_A_CLT       12'h214
`define BLD_A_CRB       12'h218
`define BLD_A_FG        12'h21c
`define BLD_A_BG        12'h220
`define BLD_A_SP        12'h224
`define BLD_A_DP        12'h228
`define BLD_A_IB        12'h22c
`define BLD_A_TS        12'h23c
`define BLD_M_CMD       32'h8403_6000
`define BLD_M_SO        32'h1fff_ffff
`define BLD_M_COL       32'h0000_ffff
`define BLD_M_CLIP      32'h03ff_07ff
`define BLD_M_SP        32'hfe00_ffff
`define BLD_M_DP        32'hf000_03ff
`define BLD_M_IB        32'he00f_fff8
`define BLD_RST         32'h0000_0000
`define BLD_CMD_SYSMEM  13
`define BLD_CMD_MONO    14
`define BLD_CMD_TREN    16
`define BLD_CMD_TRPOL   17
`define BLD_CMD_CLIP    26
`define BLD_CMD_TRDST   31
`define BLD_DP_LSBF     28
`define BLD_DP_ROT      29
`define BLD_IB_TEST     29
`define BLD_TS_ADDR     2'h0
`define BLD_TS_LR       2'h1
`define BLD_TS_TB       2'h2
`define BLD_DEP_8       2'h0
`define BLD_DEP_16      2'h1
`endif

// ==== shared/bld_pkg.sv ====
/*
 Types of the blit parameter register block: pixel request, config view, APB phase.
 Assumes bld_defines.svh is on the include path.
*/
package bld_pkg;
  typedef enum logic [0:0] {
    BLD_AP_IDLE = 1'b0,
    BLD_AP_ACK  = 1'b1
  } bld_apb_e;

  typedef struct packed {
    logic        valid;
    logic [11:0] x;
    logic [11:0] y;
    logic [7:0]  mono_byte;
    logic [2:0]  mono_idx;
    logic [15:0] src_color;
    logic [15:0] dst_color;
  } bld_pix_s;

  typedef struct packed {
    logic        mono_lsb_first;
    logic        rotate_90;
    logic [1:0]  depth;
    logic [11:0] line_start_y;
    logic [16:0] minor_axis_delta;
    logic [9:0]  dst_pitch;
    logic [9:0]  src_pitch;
    logic [2:0]  lined_bit_off;
    logic [2:0]  lined_byte_off;
    logic [2:0]  pack_bit_off;
    logic [2:0]  pack_byte_off;
    logic [9:0]  fetch_units;
    logic [6:0]  pack_gap_bits;
  } bld_cfg_s;
endpackage : bld_pkg

// ==== rtl/bld_param_regs.sv ====
/*
 Parameter registers of the 2D drawing engine behind an APB slave, plus the
 per-pixel clip, transparency and mono-expansion stage and source address math.
 Assumes the engine and the APB master run on clk_sys; no pin crosses domains.
*/
// The implementer's own choice: register access over APB.
// Summary of operation
// - Quadrant codes 0..7 decode to their major axis and signs
// - Blit source X in bits 11:0, source Y in 27:16
// - Line start Y in 11:0, 17-bit minor delta in 28:12
// - Compare colour 15:0, 8 or 16 bpp wide
// - Pixels left of or above clip window are not written
// - Pixels right of or below clip window are not written
// - Set mono bits take the foreground colour at current depth
// - Cleared mono bits take the background colour at current depth
// - Lined source pitch 9:0; display-memory source uses destination pitch
// - Lined mode bit offset 27:25, byte offset 30:28
// - Packed initial bit offset 2:0, byte offset 5:3
// - Packed bits 15:6 count 8-byte fetch units
// - Packed gap joins byte space and bit space; colour uses bytes only
// - Destination pitch 9:0 used for destination and on-screen source
// - Bit 28 selects mono pixel 0 at MSB or LSB
// - Bit 29 selects 90 degree clockwise rotation
// - Depth 31:30: 00 is 8 bpp, 01 is 16 bpp
// - Base address low three bits forced and read as zero
// - Base bit 29 enables test readout
// - Test select 00 address, 01 left/right, 10 top/bottom
// - Test select 11 shows state machine status
// - Test readout need not be defined when test mode is off
// - Command bit 31 compares against source or destination data
`timescale 1ns/1ps
`default_nettype none
`include "bld_defines.svh"
module bld_param_regs (
  // Clock, reset, enable
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               ce,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Engine side
  input  wire bld_pkg::bld_pix_s  pix_in,
  input  wire logic [2:0]         eng_quadrant,
  input  wire logic [6:0]         eng_sm_status,
  output logic                    pix_we,
  output logic      [15:0]        pix_color,
  output logic      [20:0]        src_addr,
  output logic                    ln_x_major,
  output logic                    ln_x_neg,
  output logic                    ln_y_neg,
  output bld_pkg::bld_cfg_s       cfg
);
  import bld_pkg::*;

  typedef struct packed {
    logic [31:0] cmd;
    logic [31:0] so;
    logic [31:0] cc;
    logic [31:0] clt;
    logic [31:0] crb;
    logic [31:0] fg;
    logic [31:0] bg;
    logic [31:0] sp;
    logic [31:0] dp;
    logic [31:0] ib;
    bld_apb_e    ap;
    logic [31:0] rdata;
    logic        err;
    logic        we;
    logic [15:0] color;
    logic [20:0] saddr;
    logic [8:0]  ldif;
    logic [8:0]  rdif;
    logic [11:0] tdif;
    logic [11:0] bdif;
    logic        xmaj;
    logic        xneg;
    logic        yneg;
    bld_cfg_s    cfg;
  } bld_state_s;

  bld_state_s  st_q;
  bld_state_s  st_d;
  logic        setup;
  logic        acc;
  logic        mapped;
  logic        mono_bit;
  logic        clipped;
  logic        match;
  logic        transp;
  logic        d16;
  logic [15:0] cmask;
  logic [15:0] expand;
  logic [9:0]  pitch;
  logic [21:0] yprod;
  logic [12:0] xoff;
  logic [31:0] tstat;

  assign setup = psel && !penable && (st_q.ap == BLD_AP_IDLE);
  assign acc   = psel && penable && (st_q.ap == BLD_AP_ACK);
  assign d16   = (st_q.dp[31:30] == `BLD_DEP_16);
  assign cmask = d16 ? 16'hffff : 16'h00ff;

  always_comb begin
    case (paddr)
      `BLD_A_CMD, `BLD_A_SO, `BLD_A_CC, `BLD_A_CLT, `BLD_A_CRB,
      `BLD_A_FG, `BLD_A_BG, `BLD_A_SP, `BLD_A_DP, `BLD_A_IB: mapped = 1'b1;
      `BLD_A_TS: mapped = !pwrite;
      default: mapped = 1'b0;
    endcase
  end

  assign mono_bit = st_q.dp[`BLD_DP_LSBF] ? pix_in.mono_byte[pix_in.mono_idx]
                                           : pix_in.mono_byte[3'h7 - pix_in.mono_idx];

  always_comb begin
    if (st_q.cmd[`BLD_CMD_MONO]) begin
      expand = (mono_bit ? st_q.fg[15:0] : st_q.bg[15:0]) & cmask;
    end else begin
      expand = pix_in.src_color & cmask;
    end
  end

  assign clipped = st_q.cmd[`BLD_CMD_CLIP] &&
                   ((pix_in.x < {1'b0, st_q.clt[10:0]}) ||
                    (pix_in.y < {2'b00, st_q.clt[25:16]}) ||
                    (pix_in.x > {1'b0, st_q.crb[10:0]}) ||
                    (pix_in.y > {2'b00, st_q.crb[25:16]}));

  always_comb begin
    if (st_q.cmd[`BLD_CMD_TRDST]) begin
      match = ((pix_in.dst_color ^ st_q.cc[15:0]) & cmask) == 16'h0000;
    end else begin
      match = ((expand ^ st_q.cc[15:0]) & cmask) == 16'h0000;
    end
  end
  assign transp = st_q.cmd[`BLD_CMD_TREN] && (st_q.cmd[`BLD_CMD_TRPOL] ? !match : match);

  // On-screen source steps by destination pitch
  assign pitch = st_q.cmd[`BLD_CMD_SYSMEM] ? st_q.sp[9:0] : st_q.dp[9:0];
  assign yprod = st_q.so[27:16] * pitch;
  always_comb begin
    if (st_q.cmd[`BLD_CMD_MONO]) begin
      xoff = {4'h0, st_q.so[11:3]};
    end else if (d16) begin
      xoff = {st_q.so[11:0], 1'b0};
    end else begin
      xoff = {1'b0, st_q.so[11:0]};
    end
  end

  // Test readout, zero when test mode is off
  always_comb begin
    tstat = 32'h0000_0000;
    if (st_q.ib[`BLD_IB_TEST]) begin
      case (st_q.ib[31:30])
        `BLD_TS_ADDR: tstat = {11'h000, st_q.saddr};
        `BLD_TS_LR:   tstat = {7'h00, st_q.rdif, 7'h00, st_q.ldif};
        `BLD_TS_TB:   tstat = {4'h0, st_q.bdif, 4'h0, st_q.tdif};
        default:      tstat = {25'h000_0000, eng_sm_status};
      endcase
    end
  end

  always_comb begin
    st_d = st_q;
    if (ce) begin
      case (st_q.ap)
        BLD_AP_IDLE: begin
          if (setup) begin
            st_d.ap  = BLD_AP_ACK;
            st_d.err = !mapped;
            case (paddr)
              `BLD_A_CMD: st_d.rdata = st_q.cmd;
              `BLD_A_SO:  st_d.rdata = st_q.so;
              `BLD_A_CC:  st_d.rdata = st_q.cc;
              `BLD_A_CLT: st_d.rdata = st_q.clt;
              `BLD_A_CRB: st_d.rdata = st_q.crb;
              `BLD_A_FG:  st_d.rdata = st_q.fg;
              `BLD_A_BG:  st_d.rdata = st_q.bg;
              `BLD_A_SP:  st_d.rdata = st_q.sp;
              `BLD_A_DP:  st_d.rdata = st_q.dp;
              `BLD_A_IB:  st_d.rdata = st_q.ib;
              // A refused write to the readout answers with zero data
              `BLD_A_TS:  st_d.rdata = mapped ? tstat : 32'h0000_0000;
              default:    st_d.rdata = 32'h0000_0000;
            endcase
          end
        end
        BLD_AP_ACK: begin
          st_d.ap  = BLD_AP_IDLE;
          st_d.err = 1'b0;
          // Masks keep reserved bits at zero
          if (acc && pwrite) begin
            case (paddr)
              `BLD_A_CMD: st_d.cmd = pwdata & `BLD_M_CMD;
              // Line fields share the origin register
              `BLD_A_SO:  st_d.so  = pwdata & `BLD_M_SO;
              `BLD_A_CC:  st_d.cc  = pwdata & `BLD_M_COL;
              `BLD_A_CLT: st_d.clt = pwdata & `BLD_M_CLIP;
              `BLD_A_CRB: st_d.crb = pwdata & `BLD_M_CLIP;
              `BLD_A_FG:  st_d.fg  = pwdata & `BLD_M_COL;
              `BLD_A_BG:  st_d.bg  = pwdata & `BLD_M_COL;
              `BLD_A_SP:  st_d.sp  = pwdata & `BLD_M_SP;
              `BLD_A_DP:  st_d.dp  = pwdata & `BLD_M_DP;
              `BLD_A_IB:  st_d.ib  = pwdata & `BLD_M_IB;
              default: begin
              end
            endcase
          end
        end
        default: st_d.ap = BLD_AP_IDLE;
      endcase
      st_d.we    = pix_in.valid && !clipped && !transp;
      st_d.color = expand;
      st_d.saddr = {1'b0, st_q.ib[19:3], 3'h0} + yprod[20:0] + {8'h00, xoff};
      st_d.ldif  = 9'(pix_in.x - {1'b0, st_q.clt[10:0]});
      st_d.rdif  = 9'({1'b0, st_q.crb[10:0]} - pix_in.x);
      st_d.tdif  = pix_in.y - {2'b00, st_q.clt[25:16]};
      st_d.bdif  = {2'b00, st_q.crb[25:16]} - pix_in.y;
      case (eng_quadrant)
        3'h0: {st_d.xmaj, st_d.xneg, st_d.yneg} = 3'b100;
        3'h1: {st_d.xmaj, st_d.xneg, st_d.yneg} = 3'b000;
        3'h2: {st_d.xmaj, st_d.xneg, st_d.yneg} = 3'b010;
        3'h3: {st_d.xmaj, st_d.xneg, st_d.yneg} = 3'b110;
        3'h4: {st_d.xmaj, st_d.xneg, st_d.yneg} = 3'b111;
        3'h5: {st_d.xmaj, st_d.xneg, st_d.yneg} = 3'b011;
        3'h6: {st_d.xmaj, st_d.xneg, st_d.yneg} = 3'b001;
        3'h7: {st_d.xmaj, st_d.xneg, st_d.yneg} = 3'b101;
        default: {st_d.xmaj, st_d.xneg, st_d.yneg} = 3'b100;
      endcase
      st_d.cfg.mono_lsb_first   = st_q.dp[`BLD_DP_LSBF];
      st_d.cfg.rotate_90        = st_q.dp[`BLD_DP_ROT];
      st_d.cfg.depth            = st_q.dp[31:30];
      st_d.cfg.line_start_y     = st_q.so[11:0];
      st_d.cfg.minor_axis_delta = st_q.so[28:12];
      st_d.cfg.dst_pitch        = st_q.dp[9:0];
      st_d.cfg.src_pitch        = pitch;
      st_d.cfg.lined_bit_off    = st_q.sp[27:25];
      st_d.cfg.lined_byte_off   = st_q.sp[30:28];
      st_d.cfg.pack_bit_off     = st_q.cmd[`BLD_CMD_MONO] ? st_q.sp[2:0] : 3'h0;
      st_d.cfg.pack_byte_off    = st_q.sp[5:3];
      st_d.cfg.fetch_units      = st_q.sp[15:6];
      st_d.cfg.pack_gap_bits    = st_q.cmd[`BLD_CMD_MONO] ? st_q.sp[31:25] : {st_q.sp[31:28], 3'h0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata     = st_q.rdata;
  assign pready     = (st_q.ap == BLD_AP_ACK);
  assign pslverr    = st_q.err;
  assign pix_we     = st_q.we;
  assign pix_color  = st_q.color;
  assign src_addr   = st_q.saddr;
  assign ln_x_major = st_q.xmaj;
  assign ln_x_neg   = st_q.xneg;
  assign ln_y_neg   = st_q.yneg;
  // Registered view: costs one cycle, keeps bus-side muxes off the engine's paths
  assign cfg        = st_q.cfg;

  sequence s_pix;
    ce && pix_in.valid;
  endsequence

  sequence s_setup;
    ce && setup;
  endsequence

  // Quadrant 4 is x-major with both signs negative
  AST_QUAD4: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && eng_quadrant == 3'h4) |=> (ln_x_major && ln_x_neg && ln_y_neg))
    else $error("quadrant 4 decode wrong");

  AST_QUAD6: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && eng_quadrant == 3'h6) |=> (!ln_x_major && !ln_x_neg && ln_y_neg))
    else $error("quadrant 6 decode wrong");

  AST_CLIP_LO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_pix and (st_q.cmd[`BLD_CMD_CLIP] && pix_in.x < {1'b0, st_q.clt[10:0]})) |=> !pix_we)
    else $error("pixel left of clip written");

  AST_CLIP_HI: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_pix and (st_q.cmd[`BLD_CMD_CLIP] && pix_in.y > {2'b00, st_q.crb[25:16]})) |=> !pix_we)
    else $error("pixel below clip written");

  AST_FG: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && st_q.cmd[`BLD_CMD_MONO] && mono_bit) |=> (pix_color == $past(st_q.fg[15:0] & cmask)))
    else $error("foreground expansion wrong");

  AST_BG: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && st_q.cmd[`BLD_CMD_MONO] && !mono_bit) |=> (pix_color == $past(st_q.bg[15:0] & cmask)))
    else $error("background expansion wrong");

  AST_TRDST: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_pix and (st_q.cmd[`BLD_CMD_TREN] && !st_q.cmd[`BLD_CMD_TRPOL] && st_q.cmd[`BLD_CMD_TRDST]
     && pix_in.dst_color == st_q.cc[15:0])) |=> !pix_we)
    else $error("destination transparency missed");

  AST_IB_LOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_setup and (paddr == `BLD_A_IB)) ##1 pready |-> (prdata[2:0] == 3'h0))
    else $error("base low bits read nonzero");

  AST_ACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_setup |=> (pready ##1 !pready))
    else $error("apb answer not one cycle");

  AST_UNMAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_setup and !mapped) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  AST_PACK_BIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && !st_q.cmd[`BLD_CMD_MONO]) |=> (cfg.pack_bit_off == 3'h0))
    else $error("colour source bit offset not zero");

  AST_GAP_COLOR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ce && !st_q.cmd[`BLD_CMD_MONO]) |=> (cfg.pack_gap_bits == {$past(st_q.sp[31:28]), 3'h0}))
    else $error("colour source gap not byte aligned");
endmodule : bld_param_regs
`default_nettype wire

// ==== sim/bld_engine_model.sv ====
/*
 Engine-side partner model: presents pixels, the line quadrant and state machine status.
 Assumes its task is called right after a rising edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module bld_engine_model #(
  parameter logic [6:0] STATUS = 7'h2c
) (
  // Clock
  input  wire logic         clk_sys,
  // Engine side of the block
  output bld_pkg::bld_pix_s pix_in,
  output logic [2:0]        eng_quadrant,
  output logic [6:0]        eng_sm_status
);
  import bld_pkg::*;
  initial begin
    pix_in = '0;
    eng_quadrant = 3'h0;
  end
  assign eng_sm_status = STATUS;
  // Coordinates are held after the pixel so the clip readout keeps a defined source
  task automatic put_pix(input bld_pix_s p, input logic [2:0] q);
    pix_in <= p;
    eng_quadrant <= q;
    @(posedge clk_sys);
    pix_in.valid <= 1'b0;
    @(posedge clk_sys);
  endtask : put_pix
endmodule : bld_engine_model
`default_nettype wire

// ==== sim/test_blit_line_draw_param_regs.sv ====
/*
 Self-checking bench of the blit parameter registers: APB master, engine model, note queues.
 Assumes bld_pkg is compiled first and bld_defines.svh is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bld_defines.svh"
module test_blit_line_draw_param_regs;
  import bld_pkg::*;
  localparam logic [6:0] SM = 7'h5a;
  // Quadrant decode indexed by code: major axis, x sign, y sign
  localparam logic [7:0] XM = 8'h99, XN = 8'h3c, YN = 8'hf0;
  logic        clk_sys, sys_rst, ce, psel, penable, pwrite, pready, pslverr;
  logic        pend = 1'b0;
  bld_cfg_s    ec;
  logic        pix_we, ln_x_major, ln_x_neg, ln_y_neg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, cmd, fg, bg, cc, dp, lt, rb, so, sp, n;
  logic [15:0] pix_color;
  logic [20:0] src_addr;
  logic [2:0]  eng_quadrant;
  logic [6:0]  eng_sm_status;
  logic [33:0] na;
  logic [19:0] np;
  bld_pix_s    pix_in;
  bld_cfg_s    cfg;
  int          n_errors, total_checks;
  logic [33:0] apb_q[$];
  logic [19:0] pix_q[$];
  logic [11:0] ra[10] = '{`BLD_A_CMD, `BLD_A_SO, `BLD_A_CC, `BLD_A_CLT, `BLD_A_CRB,
                          `BLD_A_FG, `BLD_A_BG, `BLD_A_SP, `BLD_A_DP, `BLD_A_IB};
  logic [31:0] rm[10] = '{`BLD_M_CMD, `BLD_M_SO, `BLD_M_COL, `BLD_M_CLIP, `BLD_M_CLIP,
                          `BLD_M_COL, `BLD_M_COL, `BLD_M_SP, `BLD_M_DP, `BLD_M_IB};
  logic [11:0] cx[7] = '{12'd10, 12'd9, 12'd100, 12'd300, 12'd301, 12'd100, 12'd100};
  logic [11:0] cy[7] = '{12'd20, 12'd50, 12'd19, 12'd200, 12'd50, 12'd201, 12'd50};

  bld_param_regs bld_param_regs_inst (.clk_sys, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pix_in, .eng_quadrant, .eng_sm_status, .pix_we,
    .pix_color, .src_addr, .ln_x_major, .ln_x_neg, .ln_y_neg, .cfg);
  bld_engine_model #(.STATUS(SM)) bld_engine_model_inst (.clk_sys, .pix_in, .eng_quadrant,
    .eng_sm_status);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] e, got);
    total_checks++;
    if (got !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", what, e, got);
    end
  endtask : check

  task automatic check_cfg(input bld_cfg_s e);
    logic [95:0] ev;
    logic [95:0] gv;
    ev = {14'h0, e};
    gv = {14'h0, cfg};
    for (int i = 0; i < 3; i++) check("cfg", ev[32*i +: 32], gv[32*i +: 32]);
  endtask : check_cfg

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [19:0] exp_pix(input bld_pix_s p, input logic [2:0] q);
    logic [15:0] m, c;
    logic        b, we;
    m = dp[31:30] == 2'h1 ? 16'hffff : 16'h00ff;
    b = dp[28] ? p.mono_byte[p.mono_idx] : p.mono_byte[3'h7 - p.mono_idx];
    c = (cmd[14] ? (b ? fg[15:0] : bg[15:0]) : p.src_color) & m;
    we = !(cmd[26] && (p.x < lt[10:0] || p.y < lt[25:16] || p.x > rb[10:0] || p.y > rb[25:16]));
    if (cmd[16] && ((((cmd[31] ? p.dst_color : c) & m) == (cc[15:0] & m)) != cmd[17])) we = 1'b0;
    return {we, c, XM[q], XN[q], YN[q]};
  endfunction : exp_pix

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, e, input logic err);
    apb_q.push_back({wr, err, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps each strobe to one assignment per time step
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask : rd

  // Readout lags a register change by one cycle, so one more cycle is let pass
  task automatic rd_ts(input logic [31:0] e);
    @(posedge clk_sys);
    rd(`BLD_A_TS, e);
  endtask : rd_ts

  task automatic pix(input logic [11:0] x, y, input logic [7:0] mb, input logic [2:0] mi,
                     input logic [15:0] s, d, input logic [2:0] q);
    bld_pix_s p;
    p = {1'b1, x, y, mb, mi, s, d};
    pix_q.push_back(exp_pix(p, q));
    bld_engine_model_inst.put_pix(p, q);
  endtask : pix

  always @(posedge clk_sys) begin
    if (psel && penable && pready) begin
      na = apb_q.pop_front();
      check("pslverr", {31'h0, na[32]}, {31'h0, pslverr});
      if (!na[33]) check("prdata", na[31:0], prdata);
    end
    if (pend) begin
      np = pix_q.pop_front();
      check("pixel", {12'h0, np}, {12'h0, pix_we, pix_color, ln_x_major, ln_x_neg, ln_y_neg});
    end
    pend <= pix_in.valid;
  end

  initial begin
    repeat (6000) @(posedge clk_sys);
    n_errors++;
    $display("[ERR] watchdog exp done got timeout");
    final_report();
  end

  initial begin
    {sys_rst, ce} = 2'b11;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    seed = 32'h707fba99;
    {cmd, fg, bg, cc, dp, lt, rb, so, sp} = '0;
    n_errors = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(ra[i], 32'h0);
      n = xs();
      wr(ra[i], n);
      rd(ra[i], n & rm[i]);
      wr(ra[i], 32'hffff_ffff);
      rd(ra[i], rm[i]);
      wr(ra[i], 32'h0);
    end
    apb(1'b0, 12'h230, 32'h0, 32'h0, 1'b1);
    apb(1'b1, `BLD_A_TS, 32'h1, 32'h0, 1'b1);
    for (int q = 0; q < 8; q++) pix(12'h1, 12'h1, 8'h0, 3'h0, 16'h0, 16'h0, q[2:0]);
    {cmd, fg, bg} = {32'h4000, 32'habcd, 32'h1234};
    wr(`BLD_A_CMD, cmd);
    wr(`BLD_A_FG, fg);
    wr(`BLD_A_BG, bg);
    for (int k = 0; k < 4; k++) begin
      dp = {1'b0, k[1], 1'b0, k[0], 28'h0};
      wr(`BLD_A_DP, dp);
      pix(12'h2, 12'h2, 8'h82, 3'h0, 16'h0, 16'h0, 3'h0);
      pix(12'h2, 12'h2, 8'h82, 3'h1, 16'h0, 16'h0, 3'h0);
    end
    dp = 32'h0;
    cc = 32'h55;
    wr(`BLD_A_DP, dp);
    wr(`BLD_A_CC, cc);
    for (int k = 0; k < 3; k++) begin
      cmd = k == 0 ? 32'h1_0000 : k == 1 ? 32'h3_0000 : 32'h8001_0000;
      wr(`BLD_A_CMD, cmd);
      pix(12'h3, 12'h3, 8'h0, 3'h0, 16'hff55, 16'h0077, 3'h0);
      pix(12'h3, 12'h3, 8'h0, 3'h0, 16'h0056, 16'h0055, 3'h0);
    end
    {lt, rb, cmd} = {32'h0014_000a, 32'h00c8_012c, 32'h0400_0000};
    wr(`BLD_A_CLT, lt);
    wr(`BLD_A_CRB, rb);
    wr(`BLD_A_CMD, cmd);
    for (int k = 0; k < 7; k++) pix(cx[k], cy[k], 8'h0, 3'h0, 16'h1234, 16'h0, 3'h0);
    wr(`BLD_A_IB, 32'h6000_0000);
    rd_ts(32'h00c8_005a);
    wr(`BLD_A_IB, 32'ha000_0000);
    rd_ts(32'h0096_001e);
    wr(`BLD_A_IB, 32'he000_0000);
    rd_ts({25'h0, SM});
    // Source pitch of 32 bytes owes no FIFO padding
    {so, sp, dp, cmd} = {32'h0003_0025, 32'h20, 32'h40, 32'h0};
    wr(`BLD_A_SO, so);
    wr(`BLD_A_SP, sp);
    wr(`BLD_A_DP, dp);
    for (int k = 0; k < 4; k++) begin
      {cmd[14], cmd[13]} = k[1:0];
      wr(`BLD_A_CMD, cmd);
      wr(`BLD_A_IB, 32'h2000_123f);
      n = {11'h0, 21'h1238 + 21'(so[27:16] * (k[0] ? sp[9:0] : dp[9:0])) + 21'(k[1] ? so[11:3] : so[11:0])};
      rd_ts(n);
      check("src_addr", n, {11'h0, src_addr});
    end
    for (int k = 0; k < 2; k++) begin
      cmd = k ? 32'h2000 : 32'h4000;
      so = xs();
      sp = xs();
      dp = xs();
      wr(`BLD_A_CMD, cmd);
      wr(`BLD_A_SO, so);
      wr(`BLD_A_SP, sp);
      wr(`BLD_A_DP, dp);
      ec = '{dp[28], dp[29], dp[31:30], so[11:0], so[28:12], dp[9:0], k ? sp[9:0] : dp[9:0], sp[27:25],
             sp[30:28], k ? 3'h0 : sp[2:0], sp[5:3], sp[15:6], k ? {sp[31:28], 3'h0} : sp[31:25]};
      // Configuration view is registered once more after the write lands
      @(posedge clk_sys);
      check_cfg(ec);
    end
    final_report();
  end
endmodule : test_blit_line_draw_param_regs
`default_nettype wire
